/* logic/fcr_regs.sv */
// Flash configuration register pair with flash disable and doze control
//
// Contract
// - flash_config_one bits 27:24 report the read-only flash size code.
// - flash_config_one bits 31:28 and 23:2 read as zero.
// - doze_flash_off set turns flash off during Doze, back on after it.
// - with doze_flash_off set, wake-up from Doze takes longer.
// - flash_off set makes flash accesses error and puts flash in low power.
// - flash_config_two is read-only; every write gives a transfer error.
// - flash_config_two bits 30:24 hold the flash limit value, unit 8 KB.
// - flash_config_two bit 23 reads one; bit 31 and bits 22:0 read zero.
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
module fcr_regs #(
   parameter logic [3:0] SIZE_CODE   = fcr_pkg::FCR_SIZE_32K,
   parameter logic [6:0] LIMIT_VALUE = fcr_pkg::FCR_LIMIT_32K
) (
   input  wire logic                            mclk,
   input  wire logic                            rst_n,
   input  wire logic [fcr_pkg::FCR_ADDR_W-1:0]  reg_addr,
   input  wire logic [fcr_pkg::FCR_DATA_W-1:0]  reg_wdata,
   input  wire logic                            reg_wr,
   input  wire logic                            reg_rd,
   output logic      [fcr_pkg::FCR_DATA_W-1:0]  reg_rdata,
   output logic                                 reg_err,
   input  wire logic                            doze_mode,
   input  wire logic                            flash_acc,
   output logic                                 flash_err,
   output logic                                 flash_en,
   output logic                                 flash_lowpower,
   output logic                                 wake_busy
);
   import fcr_pkg::*;

   // =====================================================================
   // State
   typedef struct packed {
      logic [FCR_CTL_W-1:0]  ctl;
      logic [FCR_DATA_W-1:0] rdata;
      logic                  wr_err;
      logic                  acc_err;
      logic                  lowpwr;
   } fcr_regs_type;

   fcr_regs_type st_r;
   fcr_regs_type st_nxt;

   logic         hit_one;
   logic         hit_two;
   logic         dz_en;

   // =====================================================================
   // Decode and read words
   function automatic logic fcr_hit(
      input logic [FCR_ADDR_W-1:0] addr,
      input logic [FCR_ADDR_W-1:0] off
   );
      fcr_hit = (addr == off);
   endfunction : fcr_hit

   function automatic logic [FCR_DATA_W-1:0] fcr_word_one(
      input logic [FCR_CTL_W-1:0] ctl
   );
      logic [FCR_DATA_W-1:0] w;
      w = '0;
      w[FCR_SIZE_LSB +: FCR_SIZE_W] = SIZE_CODE;
      w[FCR_DOZE_BIT]               = ctl[FCR_DOZE_BIT];
      w[FCR_OFF_BIT]                = ctl[FCR_OFF_BIT];
      fcr_word_one = w;
   endfunction : fcr_word_one

   function automatic logic [FCR_DATA_W-1:0] fcr_word_two();
      logic [FCR_DATA_W-1:0] w;
      w = '0;
      w[FCR_LIMIT_LSB +: FCR_LIMIT_W] = LIMIT_VALUE;
      w[FCR_ONE_BIT]                  = 1'b1;
      fcr_word_two = w;
   endfunction : fcr_word_two

   assign hit_one = fcr_hit(reg_addr, FCR_OFF_CFG_ONE);
   assign hit_two = fcr_hit(reg_addr, FCR_OFF_CFG_TWO);

   // =====================================================================
   // Doze sequencer
   fcr_doze_ctl u_doze (
      .mclk           (mclk),
      .rst_n          (rst_n),
      .doze_mode      (doze_mode),
      .doze_flash_off (st_r.ctl[FCR_DOZE_BIT]),
      .flash_off      (st_r.ctl[FCR_OFF_BIT]),
      .flash_en       (dz_en),
      .wake_busy      (wake_busy)
   );

   // =====================================================================
   // Register and flash-side next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.rdata = '0;
      st_nxt.wr_err = 1'b0;
      if (reg_wr && hit_one) begin
         st_nxt.ctl = reg_wdata[FCR_CTL_W-1:0];
      end
      if (reg_wr && hit_two) begin
         st_nxt.wr_err = 1'b1;
      end
      if (reg_rd && hit_one) begin
         st_nxt.rdata = fcr_word_one(st_r.ctl);
      end else if (reg_rd && hit_two) begin
         st_nxt.rdata = fcr_word_two();
      end
      // Accesses fail while flash is off or parked for doze
      st_nxt.acc_err = flash_acc && (st_r.ctl[FCR_OFF_BIT] || !dz_en);
      st_nxt.lowpwr  = st_nxt.ctl[FCR_OFF_BIT];
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '{ctl: FCR_CTL_RST, rdata: '0, wr_err: 1'b0,
                   acc_err: 1'b0, lowpwr: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // =====================================================================
   // Outputs
   assign reg_rdata      = st_r.rdata;
   assign reg_err        = st_r.wr_err;
   assign flash_err      = st_r.acc_err;
   assign flash_lowpower = st_r.lowpwr;
   assign flash_en       = dz_en;

   // =====================================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_rd_one;
      reg_rd && hit_one;
   endsequence

   sequence s_rd_two;
      reg_rd && hit_two;
   endsequence

   sequence s_wr_then_rd_one;
      reg_wr && hit_one ##1 reg_rd && hit_one;
   endsequence

   a_size_code: assert property (s_rd_one |=>
                                 reg_rdata[27:24] == SIZE_CODE)
      else $error("size code wrong on read");

   a_one_rsvd_zero: assert property (s_rd_one |=>
                                     reg_rdata[31:28] == 4'h0 &&
                                     reg_rdata[23:2] == 22'h0)
      else $error("reserved bits of config one not zero");

   a_limit_field: assert property (s_rd_two |=>
                                   reg_rdata[30:24] == LIMIT_VALUE)
      else $error("flash limit value wrong on read");

   a_two_rsvd_bits: assert property (s_rd_two |=>
                                     reg_rdata[23] && !reg_rdata[31] &&
                                     reg_rdata[22:0] == 23'h0)
      else $error("reserved bits of config two wrong");

   a_two_write_err: assert property ((reg_wr && hit_two) |=> reg_err)
      else $error("write to config two gave no transfer error");

   a_err_only_two: assert property (!(reg_wr && hit_two) |=> !reg_err)
      else $error("transfer error without a write to config two");

   a_ctl_written: assert property (s_wr_then_rd_one |=>
                                   reg_rdata[1:0] == $past(reg_wdata[1:0], 2) &&
                                   reg_rdata[27:24] == SIZE_CODE)
      else $error("config one write changed the wrong bits");

   a_off_bus_err: assert property ((flash_acc && st_r.ctl[FCR_OFF_BIT]) |=>
                                   flash_err && flash_lowpower)
      else $error("flash access while off gave no bus error");

   a_off_disables: assert property ((reg_wr && hit_one && reg_wdata[0]) |=>
                                    ##1 !flash_en)
      else $error("flash still enabled after flash_off set");

   // =====================================================================
   // Checks on control bit storage, transfer errors and read data
   sequence s_wr_one;
      reg_wr && hit_one;
   endsequence

   sequence s_wr_two;
      reg_wr && hit_two;
   endsequence

   sequence s_wr_then_rd_two;
      (reg_wr && hit_two) ##1 (reg_rd && hit_two);
   endsequence

   sequence s_rd_unmapped;
      reg_rd && !hit_one && !hit_two;
   endsequence

   sequence s_ctl_cleared;
      (reg_wr && hit_one && reg_wdata[FCR_CTL_W-1:0] == '0 && !wake_busy && !doze_mode)
      ##1 !doze_mode;
   endsequence

   a_ctl_loaded: assert property (s_wr_one |=>
                                  st_r.ctl == $past(reg_wdata[FCR_CTL_W-1:0]))
      else $error("control bits not loaded from write data");

   a_ctl_held: assert property (!(reg_wr && hit_one) |=>
                                $stable(st_r.ctl))
      else $error("control bits changed without a config one write");

   a_rd_keeps_ctl: assert property (reg_rd |=>
                                    $stable(st_r.ctl))
      else $error("control bits changed by a read");

   a_ctl_readback: assert property (s_rd_one |=>
                                    reg_rdata[FCR_CTL_W-1:0] == $past(st_r.ctl))
      else $error("control bits read back wrong");

   a_two_no_store: assert property (s_wr_two |=>
                                    $stable(st_r.ctl))
      else $error("write to config two stored data");

   a_two_write_ro: assert property (s_wr_then_rd_two |=>
                                    reg_rdata[FCR_LIMIT_LSB +: FCR_LIMIT_W] == LIMIT_VALUE &&
                                    reg_rdata[FCR_ONE_BIT])
      else $error("write to config two changed its contents");

   a_one_no_err: assert property (s_wr_one |=>
                                  !reg_err)
      else $error("transfer error on a config one write");

   a_rd_no_err: assert property (reg_rd |=>
                                 !reg_err)
      else $error("transfer error on a read");

   a_unmapped_wr: assert property ((reg_wr && !hit_one && !hit_two) |=>
                                   !reg_err && $stable(st_r.ctl))
      else $error("write to an unmapped address had an effect");

   a_rd_idle_zero: assert property (!reg_rd |=>
                                    reg_rdata == '0)
      else $error("read data shown without a read");

   a_unmapped_zero: assert property (s_rd_unmapped |=>
                                     reg_rdata == '0 && !reg_err)
      else $error("read of an unmapped address returned data");

   // =====================================================================
   // Checks on flash power and access errors
   sequence s_acc_open;
      flash_acc && !st_r.ctl[FCR_OFF_BIT] && flash_en;
   endsequence

   sequence s_acc_parked;
      flash_acc && wake_busy;
   endsequence

   sequence s_off_settled;
      flash_lowpower ##1 flash_lowpower;
   endsequence

   a_lowpwr_tracks: assert property (s_wr_one |=>
                                     flash_lowpower == $past(reg_wdata[FCR_OFF_BIT]))
      else $error("low-power state does not follow the flash_off bit");

   a_lowpwr_held: assert property (!(reg_wr && hit_one) |=>
                                   $stable(flash_lowpower))
      else $error("low-power state changed without a write");

   a_off_err_out: assert property ((flash_acc && flash_lowpower) |=>
                                   flash_err)
      else $error("no bus error on an access in low-power state");

   a_acc_open_ok: assert property (s_acc_open |=>
                                   !flash_err)
      else $error("bus error on an access to enabled flash");

   a_acc_parked: assert property (s_acc_parked |=>
                                  flash_err)
      else $error("no bus error on an access while flash parked for doze");

   a_no_acc_quiet: assert property (!flash_acc |=>
                                    !flash_err)
      else $error("bus error without a flash access");

   a_busy_blocks_en: assert property (wake_busy |->
                                      !flash_en)
      else $error("flash enabled while parked or waking");

   a_off_held_low: assert property (s_off_settled |->
                                    !flash_en)
      else $error("flash enabled while flash_off has been set");

   a_clear_enables: assert property (s_ctl_cleared |=>
                                     flash_en)
      else $error("flash not enabled after clearing both controls");

endmodule : fcr_regs

/* logic/fcr_pkg.sv */
// Constants and types shared by the flash configuration register block
package fcr_pkg;

   // =====================================================================
   // Bus widths and register offsets
   localparam int unsigned     FCR_ADDR_W      = 16;
   localparam int unsigned     FCR_DATA_W      = 32;
   localparam logic [15:0]     FCR_OFF_CFG_ONE = 16'h104C;
   localparam logic [15:0]     FCR_OFF_CFG_TWO = 16'h1050;

   // =====================================================================
   // Field layout of flash_config_one
   localparam int unsigned     FCR_SIZE_LSB    = 24;
   localparam int unsigned     FCR_SIZE_W      = 4;
   localparam int unsigned     FCR_DOZE_BIT    = 1;
   localparam int unsigned     FCR_OFF_BIT     = 0;
   localparam int unsigned     FCR_CTL_W       = 2;
   localparam logic [1:0]      FCR_CTL_RST     = 2'h0;
   localparam logic [3:0]      FCR_SIZE_8K     = 4'h0;
   localparam logic [3:0]      FCR_SIZE_16K    = 4'h1;
   localparam logic [3:0]      FCR_SIZE_32K    = 4'h3;

   // =====================================================================
   // Field layout of flash_config_two
   localparam int unsigned     FCR_LIMIT_LSB   = 24;
   localparam int unsigned     FCR_LIMIT_W     = 7;
   localparam int unsigned     FCR_LIMIT_SHIFT = 13;
   localparam int unsigned     FCR_ONE_BIT     = 23;
   localparam logic [6:0]      FCR_LIMIT_32K   = 7'h04;

   // =====================================================================
   // Doze wake-up timing
   localparam int unsigned     FCR_CLK_NS      = 100;
   localparam int unsigned     FCR_WAKE_NS     = 1000;
   localparam int unsigned     FCR_WAKE_CYC    = (FCR_WAKE_NS + FCR_CLK_NS - 1) / FCR_CLK_NS;
   localparam int unsigned     FCR_CNT_W       = 8;

   typedef enum logic [1:0] {
      FCR_RUN      = 2'b00,
      FCR_DOZE_OFF = 2'b01,
      FCR_WAKE     = 2'b10
   } fcr_doze_state_type;

endpackage : fcr_pkg

/* logic/fcr_doze_ctl.sv */
// Flash enable sequencing around Doze mode, with extended wake-up
`timescale 1ns/100ps
module fcr_doze_ctl (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic doze_mode,
   input  wire logic doze_flash_off,
   input  wire logic flash_off,
   output logic      flash_en,
   output logic      wake_busy
);
   import fcr_pkg::*;

   typedef struct packed {
      fcr_doze_state_type     st;
      logic [FCR_CNT_W-1:0]   cnt;
      logic                   en;
      logic                   busy;
   } fcr_doze_type;

   fcr_doze_type st_r;
   fcr_doze_type st_nxt;

   localparam logic [FCR_CNT_W-1:0] WAKE_LOAD = FCR_CNT_W'(FCR_WAKE_CYC - 1);

   // =====================================================================
   // Sequencer
   always_comb begin
      st_nxt = st_r;
      unique case (st_r.st)
         FCR_RUN: begin
            if (doze_mode && doze_flash_off) begin
               st_nxt.st = FCR_DOZE_OFF;
            end
         end
         FCR_DOZE_OFF: begin
            if (!doze_mode) begin
               st_nxt.st  = FCR_WAKE;
               st_nxt.cnt = WAKE_LOAD;
            end
         end
         FCR_WAKE: begin
            if (doze_mode && doze_flash_off) begin
               st_nxt.st = FCR_DOZE_OFF;
            end else if (st_r.cnt == '0) begin
               st_nxt.st = FCR_RUN;
            end else begin
               st_nxt.cnt = st_r.cnt - 1'b1;
            end
         end
         default: begin
            st_nxt.st = FCR_RUN;
         end
      endcase
      st_nxt.en   = (st_nxt.st == FCR_RUN) && !flash_off;
      st_nxt.busy = (st_nxt.st != FCR_RUN);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '{st: FCR_RUN, cnt: '0, en: 1'b1, busy: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign flash_en  = st_r.en;
   assign wake_busy = st_r.busy;

   // =====================================================================
   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_enter_doze;
      st_r.st == FCR_RUN && doze_mode && doze_flash_off;
   endsequence

   sequence s_leave_doze;
      st_r.st == FCR_DOZE_OFF && !doze_mode;
   endsequence

   sequence s_wake_quiet;
      !doze_mode && !flash_off;
   endsequence

   a_doze_disables: assert property (s_enter_doze |=> !flash_en)
      else $error("flash still enabled after entering doze");
   a_wake_extended: assert property (s_leave_doze |=> (!flash_en && wake_busy) [*8])
      else $error("flash came back too early after doze");
   a_wake_returns: assert property (s_leave_doze ##1 s_wake_quiet [*8]
                                    ##1 s_wake_quiet ##1 s_wake_quiet |=> flash_en)
      else $error("flash not re-enabled after doze wake-up");
   a_no_doze_hold: assert property (st_r.st == FCR_RUN && !doze_flash_off && !flash_off
                                    |=> flash_en)
      else $error("flash dropped in doze with doze control clear");

endmodule : fcr_doze_ctl

/* verif/fcr_cpu_model.sv */
// Processor-side register bus model for the flash configuration registers
`timescale 1ns/100ps
module fcr_cpu_model (
   input  wire logic [0:0]                     mclk,
   output logic      [fcr_pkg::FCR_ADDR_W-1:0] reg_addr,
   output logic      [fcr_pkg::FCR_DATA_W-1:0] reg_wdata,
   output logic                                reg_wr,
   output logic                                reg_rd,
   input  wire logic [fcr_pkg::FCR_DATA_W-1:0] reg_rdata,
   input  wire logic                           reg_err
);
   import fcr_pkg::*;

   // ==================================================
   // Idle bus; address and write data zero, write and read strobes low
   initial begin
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // ==================================================
   // Released lines show the inverse of the last value
   task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic e);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
      @(negedge mclk);
      e = reg_err;
      @(posedge mclk);
   endtask : wr

   task automatic rd(input logic [15:0] a, output logic [31:0] q);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(negedge mclk);
      q = reg_rdata;
      @(posedge mclk);
   endtask : rd

   // Write followed by a read of the same address with no gap
   task automatic wr_rd(input logic [15:0] a, input logic [31:0] d, output logic e,
                        output logic [31:0] q);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      reg_wdata <= ~d;
      @(negedge mclk);
      e = reg_err;
      @(posedge mclk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(negedge mclk);
      q = reg_rdata;
      @(posedge mclk);
   endtask : wr_rd
endmodule : fcr_cpu_model

/* verif/flash_config_registers_tb.sv */
// Self-checking bench for the flash configuration register block
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
   $display("mismatch at %0t: got %h expected %h", $time, a, e); end end
module flash_config_registers_tb;
   import fcr_pkg::*;
   localparam logic [3:0] SIZE = 4'h1;
   localparam logic [6:0] LIM  = 7'h02;

   logic        mclk, rst_n, reg_wr, reg_rd, reg_err, doze_mode, flash_acc;
   logic        flash_err, flash_en, flash_lowpower, wake_busy, e;
   logic [15:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, seed, d, q;
   int          n_errors, tests_run, n;

   fcr_regs #(.SIZE_CODE(SIZE), .LIMIT_VALUE(LIM)) dut_u (.mclk(mclk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_err(reg_err), .doze_mode(doze_mode),
      .flash_acc(flash_acc), .flash_err(flash_err), .flash_en(flash_en),
      .flash_lowpower(flash_lowpower), .wake_busy(wake_busy));
   fcr_cpu_model cpu_u (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_err(reg_err));

   // ==================================================
   // Expectations and helpers
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   function automatic logic [31:0] exp_one(input logic [1:0] c);
      return {4'h0, SIZE, 22'h0, c};
   endfunction : exp_one

   task automatic acc(output logic r);
      flash_acc <= 1'b1;
      @(posedge mclk);
      flash_acc <= 1'b0;
      @(negedge mclk);
      r = flash_err;
      @(posedge mclk);
   endtask : acc

   task automatic doze_run(input logic b, output int k);
      logic r;
      cpu_u.wr(FCR_OFF_CFG_ONE, {30'h0, b, 1'b0}, r);
      doze_mode <= 1'b1;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      `CHK(flash_en, ~b)
      `CHK(wake_busy, b)
      @(posedge mclk);
      acc(r);
      `CHK(r, b)
      doze_mode <= 1'b0;
      k = 0;
      @(negedge mclk);
      while (flash_en !== 1'b1 && k < 50) begin
         k++;
         @(negedge mclk);
      end
      `CHK(wake_busy, 1'b0)
   endtask : doze_run

   task automatic give_verdict();
      if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict

   // ==================================================
   // Clock, watchdog and main sequence
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   initial begin
      #1000000;
      n_errors++;
      give_verdict();
   end

   initial begin
      rst_n = 1'b0;
      doze_mode = 1'b0;
      flash_acc = 1'b0;
      n_errors = 0;
      tests_run = 0;
      seed = 32'h7E01;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      @(negedge mclk);
      `CHK(flash_en, 1'b1)
      @(posedge mclk);
      cpu_u.rd(FCR_OFF_CFG_ONE, q);
      `CHK(q, exp_one(2'h0))
      cpu_u.rd(FCR_OFF_CFG_TWO, q);
      `CHK(q, {1'b0, LIM, 1'b1, 23'h0})
      for (int i = 0; i < 12; i++) begin
         seed = lfsr_next(seed);
         d = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : seed;
         if (i[0]) begin
            cpu_u.wr_rd(FCR_OFF_CFG_ONE, d, e, q);
         end else begin
            cpu_u.wr(FCR_OFF_CFG_ONE, d, e);
            cpu_u.rd(FCR_OFF_CFG_ONE, q);
         end
         `CHK(e, 1'b0)
         `CHK(q, exp_one(d[1:0]))
         `CHK(flash_lowpower, d[0])
         acc(e);
         `CHK(e, d[0])
      end
      cpu_u.wr_rd(FCR_OFF_CFG_TWO, seed, e, q);
      `CHK(e, 1'b1)
      `CHK(q, {1'b0, LIM, 1'b1, 23'h0})
      cpu_u.wr(16'h1054, seed, e);
      `CHK(e, 1'b0)
      cpu_u.rd(16'h1054, q);
      `CHK(q, 32'h0)
      doze_run(1'b0, n);
      `CHK(n, 0)
      doze_run(1'b1, n);
      `CHK(n, FCR_WAKE_CYC + 1)
      give_verdict();
   end
endmodule : flash_config_registers_tb
